//--- logic/tes_regs.sv
// Triangle edge setup register bank with AXI4-Lite slave and scanline edge walker
module tes_regs
	import tes_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic draw_busy,
	output logic draw_left_to_right,
	output logic [31:0] depth_value,
	output logic [10:0] scan_y
);

	// ----------------------------------------
	// Register storage (parameter registers have no reset: undefined at power-on; bus and walker state is reset)
	// ----------------------------------------
	logic [31:0] depth_start_reg;
	logic [31:0] side12_x_slope_reg;
	logic [31:0] side12_last_x_reg;
	logic [31:0] side01_x_slope_reg;
	logic [31:0] side01_last_x_reg;
	logic [31:0] side02_x_slope_reg;
	logic [31:0] horiz_start_reg;
	logic [10:0] vert_start_reg;
	logic [31:0] scanline_counts_dir_reg;

	logic [15:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	tes_state_type state_reg;
	logic [31:0] x12_reg;
	logic [31:0] x01_reg;
	logic [31:0] x02_reg;
	logic [10:0] left12_reg;
	logic [10:0] left01_reg;
	logic [10:0] line_reg;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_value, input logic [31:0] new_value,
		input logic [3:0] strobes);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (strobes[i]) begin
				result[8 * i +: 8] = new_value[8 * i +: 8];
			end
		end
		return result;
	endfunction : merge_bytes

	function automatic logic [10:0] step_count(input logic [10:0] count);
		return (count != 11'h000) ? count - 11'h001 : 11'h000;
	endfunction : step_count

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [15:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
	wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
	wire wr_have_a = aw_held_reg || aw_take;
	wire wr_have_d = w_held_reg || w_take;
	wire wr_fire = wr_have_a && wr_have_d && !bvalid_reg;
	wire [15:0] wr_word = {wr_addr[15:2], 2'b00};

	wire wr_depth = wr_fire && (wr_word == TES_OFF_DEPTH_START);
	wire wr_s12 = wr_fire && (wr_word == TES_OFF_SIDE12_SLOPE);
	wire wr_l12 = wr_fire && (wr_word == TES_OFF_SIDE12_LAST);
	wire wr_s01 = wr_fire && (wr_word == TES_OFF_SIDE01_SLOPE);
	wire wr_l01 = wr_fire && (wr_word == TES_OFF_SIDE01_LAST);
	wire wr_s02 = wr_fire && (wr_word == TES_OFF_SIDE02_SLOPE);
	wire wr_xs = wr_fire && (wr_word == TES_OFF_HORIZ_START);
	wire wr_ys = wr_fire && (wr_word == TES_OFF_VERT_START);
	wire wr_cnt = wr_fire && (wr_word == TES_OFF_COUNTS_DIR);
	wire wr_ctl = wr_fire && (wr_word == TES_OFF_CONTROL);
	wire wr_ro = (wr_word == TES_OFF_STATUS) || (wr_word == TES_OFF_SIDE12_X) ||
		(wr_word == TES_OFF_SIDE01_X) || (wr_word == TES_OFF_SIDE02_X);
	wire wr_hit = wr_depth || wr_s12 || wr_l12 || wr_s01 || wr_l01 || wr_s02 || wr_xs || wr_ys || wr_cnt || wr_ctl;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= TES_RESP_OKAY;
			awaddr_reg <= 16'h0000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			aw_held_reg <= wr_fire ? 1'b0 : wr_have_a;
			w_held_reg <= wr_fire ? 1'b0 : wr_have_d;
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_hit && !wr_ro) ? TES_RESP_OKAY : TES_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Parameter registers
	// ----------------------------------------
	wire [31:0] depth_start_next = merge_bytes(depth_start_reg, wr_data, wr_strb);
	wire [31:0] side12_x_slope_next = merge_bytes(side12_x_slope_reg, wr_data, wr_strb);
	wire [31:0] side12_last_x_next = merge_bytes(side12_last_x_reg, wr_data, wr_strb);
	wire [31:0] side01_x_slope_next = merge_bytes(side01_x_slope_reg, wr_data, wr_strb);
	wire [31:0] side01_last_x_next = merge_bytes(side01_last_x_reg, wr_data, wr_strb);
	wire [31:0] side02_x_slope_next = merge_bytes(side02_x_slope_reg, wr_data, wr_strb);
	wire [31:0] horiz_start_next = merge_bytes(horiz_start_reg, wr_data, wr_strb);
	// Only the low bits of the start Y are stored; the rest read back as zero
	wire [31:0] vert_merged = merge_bytes({21'h000000, vert_start_reg}, wr_data, wr_strb);
	wire [10:0] vert_start_next = vert_merged[TES_VERT_MSB:0];
	wire [31:0] scanline_counts_dir_next = merge_bytes(scanline_counts_dir_reg, wr_data, wr_strb);

	// No reset: contents stay undefined until software writes them
	always_ff @(posedge aclk) begin
		if (wr_depth) depth_start_reg <= depth_start_next;
		if (wr_s12) side12_x_slope_reg <= side12_x_slope_next;
		if (wr_l12) side12_last_x_reg <= side12_last_x_next;
		if (wr_s01) side01_x_slope_reg <= side01_x_slope_next;
		if (wr_l01) side01_last_x_reg <= side01_last_x_next;
		if (wr_s02) side02_x_slope_reg <= side02_x_slope_next;
		if (wr_xs) horiz_start_reg <= horiz_start_next;
		if (wr_ys) vert_start_reg <= vert_start_next;
		if (wr_cnt) scanline_counts_dir_reg <= scanline_counts_dir_next;
	end

	// ----------------------------------------
	// Field decode of the count register
	// ----------------------------------------
	wire [10:0] count12 = scanline_counts_dir_reg[TES_CNT12_LSB +: TES_CNT_W];
	wire [10:0] count01 = scanline_counts_dir_reg[TES_CNT01_LSB +: TES_CNT_W];
	wire dir_ltr = scanline_counts_dir_reg[TES_DIR_BIT];
	wire [31:0] counts_view = {dir_ltr, 4'h0, count01, 5'h00, count12};
	wire start_req = wr_ctl && wr_strb[0] && wr_data[TES_CTL_START_BIT];
	wire can_draw = (count12 != 11'h000) || (count01 != 11'h000);

	// ----------------------------------------
	// Edge walker
	// ----------------------------------------
	wire walking = (state_reg == TES_RUN);
	wire left_any = (left12_reg != 11'h000) || (left01_reg != 11'h000);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= TES_IDLE;
			x12_reg <= 32'h0000_0000;
			x01_reg <= 32'h0000_0000;
			x02_reg <= 32'h0000_0000;
			left12_reg <= 11'h000;
			left01_reg <= 11'h000;
			line_reg <= 11'h000;
		end else begin
			unique case (state_reg)
				TES_IDLE: begin
					if (start_req && can_draw) begin
						state_reg <= TES_RUN;
						x12_reg <= horiz_start_reg;
						x01_reg <= horiz_start_reg;
						x02_reg <= horiz_start_reg;
						left12_reg <= count12;
						left01_reg <= count01;
						line_reg <= vert_start_reg;
					end
				end
				TES_RUN: begin
					if (!left_any) begin
						state_reg <= TES_IDLE;
					end else begin
						// Side 02 spans the full height; sides 01 then 12 share it
						x02_reg <= x02_reg + side02_x_slope_reg;
						if (left01_reg != 11'h000) begin
							x01_reg <= x01_reg + side01_x_slope_reg;
							left01_reg <= step_count(left01_reg);
						end else begin
							x12_reg <= x12_reg + side12_x_slope_reg;
							left12_reg <= step_count(left12_reg);
						end
						line_reg <= line_reg + 11'h001;
					end
				end
			endcase
		end
	end

	assign draw_busy = walking;
	assign draw_left_to_right = dir_ltr;
	assign depth_value = depth_start_reg;
	assign scan_y = line_reg;

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [15:0] rd_word = {s_axi_araddr[15:2], 2'b00};
	wire [31:0] status_view = {5'h00, line_reg, 14'h0000, dir_ltr, walking};
	logic [31:0] rd_value;
	logic rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		unique case (rd_word)
			TES_OFF_DEPTH_START: rd_value = depth_start_reg;
			TES_OFF_SIDE12_SLOPE: rd_value = side12_x_slope_reg;
			TES_OFF_SIDE12_LAST: rd_value = side12_last_x_reg;
			TES_OFF_SIDE01_SLOPE: rd_value = side01_x_slope_reg;
			TES_OFF_SIDE01_LAST: rd_value = side01_last_x_reg;
			TES_OFF_SIDE02_SLOPE: rd_value = side02_x_slope_reg;
			TES_OFF_HORIZ_START: rd_value = horiz_start_reg;
			TES_OFF_VERT_START: rd_value = {21'h000000, vert_start_reg};
			TES_OFF_COUNTS_DIR: rd_value = counts_view;
			TES_OFF_CONTROL: rd_value = 32'h0000_0000;
			TES_OFF_STATUS: rd_value = status_view;
			TES_OFF_SIDE12_X: rd_value = x12_reg;
			TES_OFF_SIDE01_X: rd_value = x01_reg;
			TES_OFF_SIDE02_X: rd_value = x02_reg;
			default: begin
				rd_value = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= TES_RESET_STATUS;
			rresp_reg <= TES_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_value;
			rresp_reg <= rd_hit ? TES_RESP_OKAY : TES_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule : tes_regs

//--- logic/tes_pkg.sv
// Package of register offsets, field positions and encodings for the triangle edge setup registers
package tes_pkg;

	localparam logic [15:0] TES_OFF_DEPTH_START = 16'hb55c;
	localparam logic [15:0] TES_OFF_SIDE12_SLOPE = 16'hb560;
	localparam logic [15:0] TES_OFF_SIDE12_LAST = 16'hb564;
	localparam logic [15:0] TES_OFF_SIDE01_SLOPE = 16'hb568;
	localparam logic [15:0] TES_OFF_SIDE01_LAST = 16'hb56c;
	localparam logic [15:0] TES_OFF_SIDE02_SLOPE = 16'hb570;
	localparam logic [15:0] TES_OFF_HORIZ_START = 16'hb574;
	localparam logic [15:0] TES_OFF_VERT_START = 16'hb578;
	localparam logic [15:0] TES_OFF_COUNTS_DIR = 16'hb57c;
	localparam logic [15:0] TES_OFF_CONTROL = 16'hb580;
	localparam logic [15:0] TES_OFF_STATUS = 16'hb584;
	localparam logic [15:0] TES_OFF_SIDE12_X = 16'hb588;
	localparam logic [15:0] TES_OFF_SIDE01_X = 16'hb58c;
	localparam logic [15:0] TES_OFF_SIDE02_X = 16'hb590;

	localparam int TES_VERT_MSB = 10;
	localparam int TES_CNT12_LSB = 0;
	localparam int TES_CNT01_LSB = 16;
	localparam int TES_CNT_W = 11;
	localparam int TES_DIR_BIT = 31;
	localparam int TES_CTL_START_BIT = 0;
	localparam int TES_STS_BUSY_BIT = 0;
	localparam int TES_STS_DIR_BIT = 1;
	localparam int TES_STS_LINE_LSB = 16;

	localparam logic [1:0] TES_RESP_OKAY = 2'b00;
	localparam logic [1:0] TES_RESP_SLVERR = 2'b10;
	localparam logic [31:0] TES_RESET_STATUS = 32'h0000_0000;

	typedef enum logic [0:0] {
		TES_IDLE,
		TES_RUN
	} tes_state_type;

endpackage : tes_pkg

//--- testbench/tes_regs_checker.sv
// Checker of bus handshakes and edge walker behaviour for the triangle edge setup registers
module tes_regs_checker
	import tes_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic draw_busy,
	input wire logic [10:0] scan_y
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_bresp_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_rdata_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_write_refuse:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	chk_read_refuse:
	assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during response");
	chk_read_answer:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
	chk_unmapped_read:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 16'hb593
		|=> s_axi_rresp == TES_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_scan_step:
	assert property (draw_busy && $past(draw_busy) && $past(aresetn) |-> scan_y == $past(scan_y) + 11'h1)
		else $error("scanline did not advance");
	chk_busy_cause:
	assert property ($rose(draw_busy) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("walker started without a write");
	chk_reset_idle:
	assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !draw_busy && scan_y == 11'h0)
		else $error("outputs not idle after reset");
endmodule : tes_regs_checker

bind tes_regs tes_regs_checker tes_regs_checker_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.draw_busy(draw_busy),
	.scan_y(scan_y)
);

//--- testbench/tes_regs_tb.sv
// Self-checking testbench of the triangle edge setup registers
module tes_regs_tb
	import tes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, draw_busy, draw_left_to_right;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, depth_value, x0, s01, s12, s02;
	logic [10:0] scan_y;
	logic [34:0] q[$];
	logic [34:0] e;
	logic [31:0] v[7];
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	localparam logic [15:0] OFFS[7] = '{TES_OFF_DEPTH_START, TES_OFF_SIDE12_SLOPE, TES_OFF_SIDE12_LAST,
		TES_OFF_SIDE01_SLOPE, TES_OFF_SIDE01_LAST, TES_OFF_SIDE02_SLOPE, TES_OFF_HORIZ_START};

	tes_regs tes_regs_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.draw_busy(draw_busy),
		.draw_left_to_right(draw_left_to_right),
		.depth_value(depth_value),
		.scan_y(scan_y)
	);

	initial begin
		forever #10 aclk = ~aclk;
	end

	task automatic test_done();
		if (failures == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t: port got %h expected %h", $time, got, exp);
		end
	endtask : ck

	// Bus master: expectation queued first, valid held until its ready
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = TES_RESP_OKAY);
		q.push_back({1'b0, r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		// Let an edge pass so the monitor takes the answer before the next request
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = TES_RESP_OKAY);
		q.push_back({1'b1, r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic wt(input logic b);
		for (int i = 0; i < 40 && draw_busy !== b; i++) @(posedge aclk);
	endtask : wt

	// ----------------------------------------
	// Response monitor and timeout
	// ----------------------------------------
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			test_done();
		end
		if ((s_axi_bvalid && s_axi_bready) === 1'b1 || (s_axi_rvalid && s_axi_rready) === 1'b1) begin
			e = q.pop_front();
			num_checks++;
			if (e[34] ? ({s_axi_rresp, s_axi_rdata} !== e[33:0]) : (s_axi_bresp !== e[33:32])) begin
				failures++;
				$display("[ERR] %0t: bus answer %h %h expected %h", $time, s_axi_rresp, s_axi_rdata, e);
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hc670c9bc));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		ck({21'h0, scan_y}, 32'h0);
		ck({31'h0, draw_busy}, 32'h0);
		@(posedge aclk);
		for (int i = 0; i < 7; i++) begin
			v[i] = (i % 2 == 0) ? ($urandom() & 32'h7fff_ffff) : $urandom();
			wr(OFFS[i], v[i]);
		end
		for (int i = 0; i < 7; i++) rd(OFFS[i], v[i]);
		ck(depth_value, v[0]);
		s_axi_wstrb <= 4'h1;
		wr(TES_OFF_DEPTH_START, 32'h0000_005a);
		s_axi_wstrb <= 4'hf;
		rd(TES_OFF_DEPTH_START, {v[0][31:8], 8'h5a});
		wr(TES_OFF_VERT_START, v[1]);
		rd(TES_OFF_VERT_START, {21'h0, v[1][10:0]});
		wr(TES_OFF_COUNTS_DIR, 32'hffff_ffff);
		rd(TES_OFF_COUNTS_DIR, 32'h87ff_07ff);
		ck({31'h0, draw_left_to_right}, 32'h1);
		wr(TES_OFF_COUNTS_DIR, 32'h0);
		ck({31'h0, draw_left_to_right}, 32'h0);
		wr(TES_OFF_CONTROL, 32'h1);
		repeat (10) @(posedge aclk);
		ck({31'h0, draw_busy}, 32'h0);
		x0 = $urandom() & 32'h3fff_ffff;
		s01 = ($urandom() & 32'h001f_ffff) - 32'h0010_0000;
		s12 = ($urandom() & 32'h001f_ffff) - 32'h0010_0000;
		s02 = ($urandom() & 32'h001f_ffff) - 32'h0010_0000;
		wr(TES_OFF_HORIZ_START, x0);
		wr(TES_OFF_SIDE01_SLOPE, s01);
		wr(TES_OFF_SIDE12_SLOPE, s12);
		wr(TES_OFF_SIDE02_SLOPE, s02);
		wr(TES_OFF_VERT_START, 32'h5);
		wr(TES_OFF_COUNTS_DIR, 32'h8002_0003);
		wr(TES_OFF_CONTROL, 32'h1);
		wt(1'b1);
		ck({31'h0, draw_busy}, 32'h1);
		wt(1'b0);
		ck({21'h0, scan_y}, 32'ha);
		rd(TES_OFF_SIDE01_X, x0 + 2 * s01);
		rd(TES_OFF_SIDE12_X, x0 + 3 * s12);
		rd(TES_OFF_SIDE02_X, x0 + 5 * s02);
		wr(16'hb600, 32'h0, TES_RESP_SLVERR);
		rd(16'hb600, 32'h0, TES_RESP_SLVERR);
		wr(TES_OFF_STATUS, 32'h0, TES_RESP_SLVERR);
		test_done();
	end
endmodule : tes_regs_tb
